// File: vcbhp_pkg.sv
// command-block host port: register map, field positions and timing
// assumes a 100 MHz board clock and a byte-wide slave data path
package vcbhp_pkg;

    // ------------------------------------------------------------
    // register offsets (byte addresses); index is offset bits 3:1
    // ------------------------------------------------------------
    localparam logic [3:0] OFS_ADDR0 = 4'h1;
    localparam logic [3:0] OFS_ADDR3 = 4'h7;
    localparam logic [3:0] OFS_AM    = 4'h9;
    localparam logic [3:0] OFS_CSR   = 4'hb;
    localparam logic [3:0] OFS_FATAL = 4'hd;

    // ------------------------------------------------------------
    // control (write) and status (read) bit positions
    // ------------------------------------------------------------
    localparam int CSR_CRST = 3;
    localparam int CSR_ADD  = 2;
    localparam int CSR_CLRD = 1;
    localparam int STS_BUSY = 7;
    localparam int STS_FERR = 6;
    localparam int STS_PEND = 2;
    localparam int STS_DONE = 1;

    // ------------------------------------------------------------
    // decode, arbitration and block constants
    // ------------------------------------------------------------
    localparam logic [5:0]  AM_SHORT_SUP = 6'h2d;
    localparam logic [5:0]  AM_SHORT_USR = 6'h29;
    localparam logic [15:0] DEF_BASE     = 16'heec0;
    localparam logic [11:0] DEF_BASE_INS = ~DEF_BASE[15:4];
    localparam logic [1:0]  DEF_BR_LEVEL = 2'h3;
    localparam int          NUM_LEVELS   = 4;
    localparam logic [5:0]  BLOCK_BYTES  = 6'h24;
    localparam logic        RATE_4MHZ    = 1'b0;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS         = 10;
    localparam int YELLOW_NS      = 100_000_000;
    localparam int YELLOW_CYC_DEF = YELLOW_NS / CLK_NS;

    typedef enum logic {SL_IDLE, SL_ACK} vcbhp_slave_t;

endpackage : vcbhp_pkg

// File: vcbhp_sync3.sv
// three-stage input synchroniser, one lane per bit
// assumes inputs are asynchronous pins; output moves once stages agree
`timescale 1ns/100ps
module vcbhp_sync3 #(
    parameter int               WIDTH     = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input  wire logic             clk,     // board clock
    input  wire logic             rst_n,   // synchronous-release reset
    input  wire logic [WIDTH-1:0] pin_i,   // raw pins
    output logic      [WIDTH-1:0] sync_o   // filtered copy
);
    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;

    genvar g;
    generate
        for (g = 0; g < WIDTH; g++) begin : g_lane
            logic out_d;
            always_comb begin
                out_d = (s2_q[g] == s3_q[g]) ? s3_q[g] : sync_o[g];
            end
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    s1_q[g]   <= RESET_VAL[g];
                    s2_q[g]   <= RESET_VAL[g];
                    s3_q[g]   <= RESET_VAL[g];
                    sync_o[g] <= RESET_VAL[g];
                end else begin
                    s1_q[g]   <= pin_i[g];
                    s2_q[g]   <= s1_q[g];
                    s3_q[g]   <= s2_q[g];
                    sync_o[g] <= out_d;
                end
            end
        end
    endgenerate

endmodule : vcbhp_sync3

// File: vcbhp_top.sv
// command-block host port: A16 slave registers, add/done handshake,
// bus request and grant daisy chain, rate option and status lamps
// assumes an engine on the same clock does DMA and block execution
//
// How it works
// - every command block moved to or from host memory is 36 bytes
// - seven byte registers; word access drives and samples only low byte
// - order: four address bytes, modifier, control/status, fatal error
// - device captures address, clears add flag, fetches and runs block
// - on finish, status updated, block written back, done flag set
// - while done flag set, address registers read the completed address
// - adds accepted whenever add flag clear, even while still busy
// - inserted option needs line low, removed option needs line high
// - address bits 1 to 3 pick the register
// - answer modifier 2DH, and 29H only when enabled; base EEC0
// - request on exactly one of four levels, wait for its grant
// - grant on a level not requested passes to grant out
// - default request level is 3
// - rate option caps SCSI at 4 or 5 MHz, default 4
// - green lamp on while work is in progress
// - yellow lamp brief at power-up, stays on for fatal or self-test
`timescale 1ns/100ps
module vcbhp_top import vcbhp_pkg::*; #(
    parameter int unsigned YELLOW_CYCLES = YELLOW_CYC_DEF,
    parameter logic [1:0]  BR_LEVEL      = DEF_BR_LEVEL
) (
    input  wire logic        clk,            // board clock
    input  wire logic        reset_n,        // power-up reset
    input  wire logic [15:1] vme_addr,       // slave address
    input  wire logic [5:0]  vme_am,         // address modifier
    input  wire logic        vme_as_n,       // address strobe
    input  wire logic        vme_ds_n,       // low byte data strobe
    input  wire logic        vme_write_n,    // low = write
    input  wire logic [7:0]  vme_data_i,     // data lines in
    output logic      [7:0]  vme_data_o,     // data lines out
    output logic             vme_data_oe_n,  // low while driving data
    output logic             vme_dtack_n,    // acknowledge level
    output logic             vme_dtack_oe_n, // low while driving ack
    input  wire logic [11:0] base_opt_ins,   // 1 = option inserted
    input  wire logic        am29_en,        // accept 29H too
    input  wire logic        scsi_rate_opt,  // 1 = 5 MHz option
    input  wire logic [3:0]  bg_in_n,        // grant in chain
    output logic      [3:0]  bg_out_n,       // grant out chain
    output logic      [3:0]  br_n,           // bus requests
    output logic             cmd_valid,      // queued block ready
    output logic      [31:0] cmd_addr,       // queued block address
    output logic      [7:0]  cmd_am,         // queued block modifier
    output logic      [5:0]  cmd_bytes,      // block length to fetch
    input  wire logic        cmd_ready,      // engine takes block
    input  wire logic        done_valid,     // engine finished block
    input  wire logic [31:0] done_addr,      // finished block address
    input  wire logic [7:0]  done_am,        // finished block modifier
    output logic             done_ready,     // done slot free
    input  wire logic        engine_busy,    // engine has work
    input  wire logic        fatal_valid,    // fatal event
    input  wire logic [7:0]  fatal_code,     // fatal cause
    input  wire logic        selftest_fail,  // self-test failed
    output logic             ctl_reset,      // soft reset pulse
    input  wire logic        dma_req,        // engine wants bus
    output logic             dma_grant,      // bus is ours
    output logic             scsi_rate_5mhz, // 1 = 5 MHz cap
    output logic             led_green,      // activity lamp
    output logic             led_yellow      // fault lamp
);
    localparam logic [2:0] IDX_ADDR0 = OFS_ADDR0[3:1];
    localparam logic [2:0] IDX_ADDR3 = OFS_ADDR3[3:1];
    localparam logic [2:0] IDX_AM    = OFS_AM[3:1];
    localparam logic [2:0] IDX_CSR   = OFS_CSR[3:1];
    localparam logic [2:0] IDX_FATAL = OFS_FATAL[3:1];
    localparam logic [1:0] PASS_LVL  = BR_LEVEL + 2'h1;

    // ------------------------------------------------------------
    // reset release and input synchronisers
    // ------------------------------------------------------------
    logic rst_s1_q;
    logic rst_n_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_q <= 1'b0;
            rst_n_q  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_q  <= rst_s1_q;
        end
    end

    logic [31:0] bus_s;
    logic [17:0] opt_s;
    vcbhp_sync3 #(.WIDTH(32), .RESET_VAL(32'he000_0000)) u_bus_sync (
        .clk    (clk),
        .rst_n  (rst_n_q),
        .pin_i  ({vme_as_n, vme_ds_n, vme_write_n, vme_am, vme_addr, vme_data_i}),
        .sync_o (bus_s)
    );
    vcbhp_sync3 #(.WIDTH(18), .RESET_VAL({DEF_BASE_INS, 2'h0, 4'hf})) u_opt_sync (
        .clk    (clk),
        .rst_n  (rst_n_q),
        .pin_i  ({base_opt_ins, am29_en, scsi_rate_opt, bg_in_n}),
        .sync_o (opt_s)
    );

    logic        s_as_n;
    logic        s_ds_n;
    logic        s_write_n;
    logic [5:0]  s_am;
    logic [15:1] s_addr;
    logic [7:0]  s_data;
    logic [11:0] s_ins;
    logic        s_am29;
    logic        s_rate;
    logic [3:0]  s_bg_in_n;
    assign {s_as_n, s_ds_n, s_write_n, s_am, s_addr, s_data} = bus_s;
    assign {s_ins, s_am29, s_rate, s_bg_in_n} = opt_s;

    // ------------------------------------------------------------
    // slave decode
    // ------------------------------------------------------------
    logic       base_hit;
    logic       am_hit;
    logic       cyc;
    logic [2:0] idx;
    assign base_hit = &(s_addr[15:4] ^ s_ins);
    assign am_hit   = (s_am == AM_SHORT_SUP) || (s_am29 && s_am == AM_SHORT_USR);
    assign cyc      = !s_as_n && !s_ds_n && base_hit && am_hit;
    assign idx      = s_addr[3:1];

    // ------------------------------------------------------------
    // slave and register state
    // ------------------------------------------------------------
    vcbhp_slave_t sl_q, sl_d;
    logic [31:0] addr_wr_q, addr_wr_d;
    logic [7:0]  am_wr_q, am_wr_d;
    logic        pend_q, pend_d;
    logic [31:0] cmd_addr_d;
    logic [7:0]  cmd_am_d;
    logic [5:0]  cmd_bytes_d;
    logic        done_q, done_d;
    logic [31:0] done_addr_q, done_addr_d;
    logic [7:0]  done_am_q, done_am_d;
    logic        done_ready_d;
    logic        ferr_q, ferr_d;
    logic [7:0]  fcode_q, fcode_d;
    logic        busy_q, busy_d;
    logic        ctl_reset_d;
    logic [7:0]  rd_val;
    logic [7:0]  data_o_d;
    logic        data_oe_n_d;
    logic        dtack_n_d;

    // completed address shadows the written one while done is up
    always_comb begin
        rd_val = 8'h00;
        if (idx <= IDX_ADDR3) begin
            rd_val = done_q ? done_addr_q[8*idx +: 8] : addr_wr_q[8*idx +: 8];
        end else if (idx == IDX_AM) begin
            rd_val = done_q ? done_am_q : am_wr_q;
        end else if (idx == IDX_CSR) begin
            rd_val = 8'h00;
            rd_val[STS_BUSY] = busy_q;
            rd_val[STS_FERR] = ferr_q;
            rd_val[STS_PEND] = pend_q;
            rd_val[STS_DONE] = done_q;
        end else if (idx == IDX_FATAL) begin
            rd_val = fcode_q;
        end
    end

    always_comb begin
        sl_d         = sl_q;
        addr_wr_d    = addr_wr_q;
        am_wr_d      = am_wr_q;
        pend_d       = pend_q;
        cmd_addr_d   = cmd_addr;
        cmd_am_d     = cmd_am;
        cmd_bytes_d  = cmd_bytes;
        done_d       = done_q;
        done_addr_d  = done_addr_q;
        done_am_d    = done_am_q;
        ferr_d       = ferr_q;
        fcode_d      = fcode_q;
        ctl_reset_d  = 1'b0;
        data_o_d     = vme_data_o;
        data_oe_n_d  = vme_data_oe_n;
        dtack_n_d    = vme_dtack_n;
        // engine takes the queued block; add flag drops
        if (pend_q && cmd_ready) begin
            pend_d = 1'b0;
        end
        case (sl_q)
            SL_IDLE: begin
                if (cyc) begin
                    sl_d      = SL_ACK;
                    dtack_n_d = 1'b0;
                    if (s_write_n) begin
                        data_o_d    = rd_val;
                        data_oe_n_d = 1'b0;
                    end else if (idx <= IDX_ADDR3) begin
                        addr_wr_d[8*idx +: 8] = s_data;
                    end else if (idx == IDX_AM) begin
                        am_wr_d = s_data;
                    end else if (idx == IDX_CSR) begin
                        if (s_data[CSR_CRST]) begin
                            // pending block dropped, done cleared; a done_valid in the same cycle sets done only if done was already clear
                            pend_d      = 1'b0;
                            done_d      = 1'b0;
                            ferr_d      = 1'b0;
                            fcode_d     = 8'h00;
                            ctl_reset_d = 1'b1;
                        end else begin
                            // second add while pending is ignored
                            if (s_data[CSR_ADD] && !pend_q) begin
                                pend_d      = 1'b1;
                                cmd_addr_d  = addr_wr_q;
                                cmd_am_d    = am_wr_q;
                                cmd_bytes_d = BLOCK_BYTES;
                            end
                            if (s_data[CSR_CLRD] && done_q) begin
                                done_d = 1'b0;
                            end
                        end
                    end
                end
            end
            SL_ACK: begin
                if (s_ds_n || s_as_n) begin
                    sl_d        = SL_IDLE;
                    dtack_n_d   = 1'b1;
                    data_oe_n_d = 1'b1;
                end
            end
            default: sl_d = SL_IDLE;
        endcase
        // completion waits while the slot is full, so none is lost
        if (done_valid && !done_q) begin
            done_d      = 1'b1;
            done_addr_d = done_addr;
            done_am_d   = done_am;
        end
        if (fatal_valid) begin
            ferr_d  = 1'b1;
            fcode_d = fatal_code;
        end
        done_ready_d = !done_d;
        busy_d       = engine_busy || pend_q;
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            sl_q           <= SL_IDLE;
            addr_wr_q      <= 32'h0000_0000;
            am_wr_q        <= 8'h00;
            pend_q         <= 1'b0;
            cmd_addr       <= 32'h0000_0000;
            cmd_am         <= 8'h00;
            cmd_bytes      <= 6'h00;
            done_q         <= 1'b0;
            done_addr_q    <= 32'h0000_0000;
            done_am_q      <= 8'h00;
            done_ready     <= 1'b0;
            ferr_q         <= 1'b0;
            fcode_q        <= 8'h00;
            busy_q         <= 1'b0;
            ctl_reset      <= 1'b0;
            vme_data_o     <= 8'h00;
            vme_data_oe_n  <= 1'b1;
            vme_dtack_n    <= 1'b1;
            vme_dtack_oe_n <= 1'b1;
        end else begin
            sl_q           <= sl_d;
            addr_wr_q      <= addr_wr_d;
            am_wr_q        <= am_wr_d;
            pend_q         <= pend_d;
            cmd_addr       <= cmd_addr_d;
            cmd_am         <= cmd_am_d;
            cmd_bytes      <= cmd_bytes_d;
            done_q         <= done_d;
            done_addr_q    <= done_addr_d;
            done_am_q      <= done_am_d;
            done_ready     <= done_ready_d;
            ferr_q         <= ferr_d;
            fcode_q        <= fcode_d;
            busy_q         <= busy_d;
            ctl_reset      <= ctl_reset_d;
            vme_data_o     <= data_o_d;
            vme_data_oe_n  <= data_oe_n_d;
            vme_dtack_n    <= dtack_n_d;
            vme_dtack_oe_n <= dtack_n_d;
        end
    end
    assign cmd_valid = pend_q;

    // ------------------------------------------------------------
    // arbitration: one request level, grant daisy chain
    // ------------------------------------------------------------
    logic [3:0] br_n_d;
    logic [3:0] bg_out_n_d;
    logic       own_d;
    always_comb begin
        br_n_d = 4'hf;
        br_n_d[BR_LEVEL] = !(dma_req && !dma_grant);
        own_d = dma_req && (dma_grant || !s_bg_in_n[BR_LEVEL]);
        for (int i = 0; i < NUM_LEVELS; i++) begin
            // own level blocked only while we want or hold the bus
            if (i == int'(BR_LEVEL) && (dma_req || dma_grant)) begin
                bg_out_n_d[i] = 1'b1;
            end else begin
                bg_out_n_d[i] = s_bg_in_n[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            br_n      <= 4'hf;
            bg_out_n  <= 4'hf;
            dma_grant <= 1'b0;
        end else begin
            br_n      <= br_n_d;
            bg_out_n  <= bg_out_n_d;
            dma_grant <= own_d;
        end
    end

    // ------------------------------------------------------------
    // lamps and rate option
    // ------------------------------------------------------------
    logic [31:0] lamp_cnt_q, lamp_cnt_d;
    logic        yellow_d;
    always_comb begin
        lamp_cnt_d = (lamp_cnt_q == YELLOW_CYCLES) ? lamp_cnt_q : lamp_cnt_q + 32'h1;
        yellow_d   = (lamp_cnt_q != YELLOW_CYCLES) || ferr_q || selftest_fail;
    end

    always_ff @(posedge clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lamp_cnt_q     <= 32'h0;
            led_yellow     <= 1'b1;
            led_green      <= 1'b0;
            scsi_rate_5mhz <= RATE_4MHZ;
        end else begin
            lamp_cnt_q     <= lamp_cnt_d;
            led_yellow     <= yellow_d;
            led_green      <= busy_q;
            scsi_rate_5mhz <= s_rate;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n_q);

    sequence s_csr_wr;
        sl_q == SL_IDLE && cyc && !s_write_n && idx == IDX_CSR;
    endsequence
    sequence s_add_wr;
        s_csr_wr and (s_data[CSR_ADD] && !s_data[CSR_CRST] && !pend_q);
    endsequence
    sequence s_done_clr;
        s_csr_wr and (s_data[CSR_CLRD] || s_data[CSR_CRST]);
    endsequence
    // same decode as s_done_clr, as a plain level so it can be negated
    logic clr_wr;
    assign clr_wr = sl_q == SL_IDLE && cyc && !s_write_n && idx == IDX_CSR
        && (s_data[CSR_CLRD] || s_data[CSR_CRST]);

    a_add_snapshot: assert property (s_add_wr |=> pend_q && cmd_valid
        && cmd_addr == $past(addr_wr_q) && cmd_am == $past(am_wr_q))
        else $error("add did not snapshot address");
    a_add_accept: assert property (pend_q && cmd_ready |=> !pend_q)
        else $error("add flag not cleared on accept");
    a_done_hold: assert property (done_q && !clr_wr
        |=> done_q && $stable(done_addr_q) && $stable(done_am_q))
        else $error("completed address changed while held");
    a_done_read: assert property (sl_q == SL_IDLE && cyc && s_write_n
        && idx == IDX_ADDR0 && done_q |=> vme_data_o == done_addr_q[7:0])
        else $error("read did not show completed address");
    a_done_set: assert property (done_valid && done_ready
        |=> done_q && !done_ready && done_addr_q == $past(done_addr))
        else $error("completion not flagged");
    a_done_clear: assert property (s_done_clr ##0 done_q |=> !done_q)
        else $error("done flag not cleared by host");
    a_no_match: assert property (sl_q == SL_IDLE && !(base_hit && am_hit)
        |=> vme_dtack_n && vme_dtack_oe_n)
        else $error("answered outside the base or modifier");
    a_ack_release: assert property (sl_q == SL_ACK && s_ds_n
        |=> vme_dtack_n && vme_data_oe_n ##1 sl_q == SL_IDLE)
        else $error("ack not released after strobe");
    a_one_level: assert property ((br_n | (4'h1 << BR_LEVEL)) == 4'hf)
        else $error("request on a foreign level");
    a_grant_pass: assert property (1'b1 |=> bg_out_n[PASS_LVL] == $past(s_bg_in_n[PASS_LVL]))
        else $error("foreign grant not passed on");
    a_yellow_fatal: assert property (ferr_q |=> led_yellow)
        else $error("yellow lamp off with fatal error");
    a_green_busy: assert property (busy_q |=> led_green)
        else $error("green lamp off while busy");

endmodule : vcbhp_top

// File: vcbhp_host.sv
// host processor model: byte register cycles on the A16 slave port
// assumes the device acks within 40 clocks, otherwise the cycle is dropped
`timescale 1ns/100ps
module vcbhp_host (
    input  wire logic        clk,     // board clock
    output logic      [15:1] addr,    // address pins
    output logic      [5:0]  am,      // modifier pins
    output logic             as_n,    // address strobe
    output logic             ds_n,    // low byte data strobe
    output logic             wr_n,    // low = write
    output logic      [7:0]  wdata,   // data to device
    input  wire logic [7:0]  rdata,   // data from device
    input  wire logic        dtack_n  // device ack
);
    initial begin
        addr = '0;
        am = '0;
        as_n = 1'b1;
        ds_n = 1'b1;
        wr_n = 1'b1;
        wdata = 8'h00;
    end

    task automatic acc(input logic w, input logic [15:1] a, input logic [5:0] m,
                       input logic [7:0] d, output logic [7:0] q, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        q = 8'h00;
        @(posedge clk);
        addr <= a;
        am <= m;
        wr_n <= ~w;
        wdata <= d;
        as_n <= 1'b0;
        ds_n <= 1'b0;
        while (!ok && n < 40) begin
            @(posedge clk);
            if (dtack_n === 1'b0) begin
                ok = 1'b1;
                q = rdata;
            end
            n++;
        end
        // released lines must not keep showing the old value
        as_n <= 1'b1;
        ds_n <= 1'b1;
        wr_n <= 1'b1;
        wdata <= ~d;
        addr <= ~a;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (dtack_n !== 1'b1 && n < 20);
    endtask : acc
endmodule : vcbhp_host

// File: vcbhp_top_test.sv
// testbench for the command-block host port
// assumes the host model in vcbhp_host.sv and a 20-cycle yellow lamp
`timescale 1ns/100ps
module vcbhp_top_test import vcbhp_pkg::*;;
    logic clk = 0, reset_n = 0, as_n, ds_n, wr_n, doe_n, dt_n, dtoe_n, am29 = 0, rate = 0;
    logic cmd_ready = 0, done_valid = 0, busy = 0, fatal = 0, stf = 0, dma_req = 0;
    logic cmd_valid, done_ready, ctl_reset, dma_grant, r5, lg, ly, ok;
    logic [15:1] a;
    logic [5:0]  am, cmd_bytes, m = AM_SHORT_SUP;
    logic [7:0]  di, dout, done_am = 8'h2d, fcode = 8'h00, cmd_am, q;
    logic [3:0]  bgi_n = 4'hf, bgo_n, br_n;
    logic [31:0] done_addr = 32'hc0de5a10, cmd_addr;
    logic [11:0] base = DEF_BASE[15:4];
    int fail_count = 0, n_compared = 0;
    int n_soft = 0, oe_bad = 0;

    always #5 clk = ~clk;

    // enables must move with the ack; soft reset must be a single pulse
    always @(posedge clk) begin
        if (ctl_reset === 1'b1) n_soft++;
        if (reset_n && (dtoe_n !== dt_n || (doe_n === 1'b0 && dt_n !== 1'b0))) oe_bad++;
    end

    vcbhp_host i_vcbhp_host (.clk(clk), .addr(a), .am(am), .as_n(as_n), .ds_n(ds_n),
        .wr_n(wr_n), .wdata(di), .rdata(dout), .dtack_n(dt_n));

    vcbhp_top #(.YELLOW_CYCLES(20)) i_vcbhp_top (.clk(clk), .reset_n(reset_n),
        .vme_addr(a), .vme_am(am), .vme_as_n(as_n), .vme_ds_n(ds_n), .vme_write_n(wr_n),
        .vme_data_i(di), .vme_data_o(dout), .vme_data_oe_n(doe_n), .vme_dtack_n(dt_n),
        .vme_dtack_oe_n(dtoe_n), .base_opt_ins(DEF_BASE_INS), .am29_en(am29),
        .scsi_rate_opt(rate), .bg_in_n(bgi_n), .bg_out_n(bgo_n), .br_n(br_n),
        .cmd_valid(cmd_valid), .cmd_addr(cmd_addr), .cmd_am(cmd_am), .cmd_bytes(cmd_bytes),
        .cmd_ready(cmd_ready), .done_valid(done_valid), .done_addr(done_addr),
        .done_am(done_am), .done_ready(done_ready), .engine_busy(busy), .fatal_valid(fatal),
        .fatal_code(fcode), .selftest_fail(stf), .ctl_reset(ctl_reset), .dma_req(dma_req),
        .dma_grant(dma_grant), .scsi_rate_5mhz(r5), .led_green(lg), .led_yellow(ly));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic end_sim;
        if (fail_count == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    task automatic wr(logic [2:0] i, logic [7:0] d);
        i_vcbhp_host.acc(1'b1, {base, i}, m, d, q, ok);
        chk("wr_ack", ok, 1);
    endtask : wr

    task automatic rd(string nm, logic [2:0] i, logic [7:0] e);
        i_vcbhp_host.acc(1'b0, {base, i}, m, 8'h00, q, ok);
        chk(nm, {ok, q}, {1'b1, e});
    endtask : rd

    task automatic step(int n);
        repeat (n) @(posedge clk);
    endtask : step

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    initial begin
        step(12);
        reset_n <= 1'b1;
        step(8);
        chk("br_idle", br_n, 4'hf);
        chk("yellow_boot", ly, 1);
        rd("csr_idle", 3'h5, 8'h00);
        step(20);
        chk("yellow_off", ly, 0);
        chk("rate4", r5, 0);
        rate <= 1'b1;
        for (int k = 0; k < 4; k++) wr(k[2:0], 8'h11 * (k + 1));
        wr(3'h4, 8'h2d);
        wr(3'h5, 8'h04);
        chk("cmd_valid", cmd_valid, 1);
        chk("cmd_addr", cmd_addr, 32'h44332211);
        chk("cmd_am", cmd_am, 8'h2d);
        chk("cmd_bytes", cmd_bytes, 6'h24);
        rd("csr_pend", 3'h5, 8'h84);
        wr(3'h0, 8'h99);
        chk("snapshot", cmd_addr, 32'h44332211);
        chk("green", lg, 1);
        chk("rate5", r5, 1);
        for (int k = 0; k < 2; k++) begin
            cmd_ready <= 1'b1;
            step(1);
            cmd_ready <= 1'b0;
            busy <= 1'b1;
            step(2);
            chk("taken", cmd_valid, 0);
            if (k == 0) begin
                rd("pend_clear", 3'h5, 8'h80);
                wr(3'h5, 8'h04);
                chk("add_busy", cmd_addr, 32'h44332299);
            end
        end
        chk("done_free", done_ready, 1);
        done_valid <= 1'b1;
        step(1);
        done_addr <= 32'h0badf00d;
        step(2);
        chk("done_held", done_ready, 0);
        for (int k = 0; k < 4; k++) rd("done_addr", k[2:0], 8'h10 + 8'h4a * (k == 1)
            + 8'hce * (k == 2) + 8'hb0 * (k == 3));
        rd("done_am", 3'h4, 8'h2d);
        rd("csr_done", 3'h5, 8'h82);
        wr(3'h5, 8'h02);
        step(3);
        done_valid <= 1'b0;
        rd("next_addr", 3'h0, 8'h0d);
        wr(3'h5, 8'h02);
        busy <= 1'b0;
        rd("csr_clear", 3'h5, 8'h00);
        chk("green_off", lg, 0);
        m = AM_SHORT_USR;
        i_vcbhp_host.acc(1'b0, {base, 3'h5}, m, 8'h00, q, ok);
        chk("am29_off", ok, 0);
        am29 <= 1'b1;
        step(6);
        rd("am29_on", 3'h5, 8'h00);
        m = AM_SHORT_SUP;
        i_vcbhp_host.acc(1'b0, {base ^ 12'h801, 3'h5}, m, 8'h00, q, ok);
        chk("base_miss", ok, 0);
        dma_req <= 1'b1;
        step(3);
        chk("br_level", br_n, 4'h7);
        bgi_n <= 4'h6;
        step(7);
        chk("grant", dma_grant, 1);
        chk("pass", bgo_n, 4'he);
        dma_req <= 1'b0;
        bgi_n <= 4'hf;
        fcode <= 8'h5a;
        fatal <= 1'b1;
        step(1);
        fatal <= 1'b0;
        rd("fatal_code", 3'h6, 8'h5a);
        chk("yellow_on", ly, 1);
        wr(3'h5, 8'h08);
        rd("fatal_clr", 3'h6, 8'h00);
        chk("yellow_clr", ly, 0);
        stf <= 1'b1;
        step(2);
        chk("yellow_st", ly, 1);
        chk("soft_pulse", n_soft, 1);
        chk("oe_pair", oe_bad, 0);
        end_sim();
    end

    initial begin
        #200_000;
        fail_count++;
        end_sim();
    end
endmodule : vcbhp_top_test
